// ---- hdl/hfb_top.sv ----
// host byte buffer: register port, main buffer, alerts, irq status
`timescale 1ns/1ps
module hfb_top
  import hfb_pkg::*;
(
  input  wire logic       clk,          // 125 MHz clock
  input  wire logic       reset_n,      // sync reset, low
  input  wire logic       acc_start,    // loads address pointer
  input  wire logic [7:0] acc_addr,     // start address
  input  wire logic       reg_wr,       // byte write at pointer
  input  wire logic       reg_rd,       // byte read at pointer
  input  wire logic [7:0] reg_wdata,    // write byte
  output logic      [7:0] reg_rdata,    // read byte
  output logic            reg_rvalid,   // read byte valid pulse
  output logic      [7:0] addr_ptr,     // current pointer
  input  wire logic       mdm_valid,    // modem byte offered
  input  wire logic [7:0] mdm_data,     // modem byte
  output logic            mdm_ready,    // staging fifo has room
  output logic            high_alert,   // high alert level
  output logic            low_alert,    // low alert level
  output logic      [6:0] irq_a,        // status register a
  output logic      [6:0] irq_b         // status register b
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] mem_r [MEM_WORDS];
  logic [8:0] wp_r;
  logic [8:0] rp_r;
  logic [9:0] cnt_r;
  logic       depth_sel_r;
  logic       thr_msb_r;
  logic [7:0] thr_r;
  logic       wr_err_r;
  logic       ovl_err_r;
  logic       hi_prev_r;
  logic       lo_prev_r;
  logic       ovl_prev_r;
  logic       wr_err_prev_r;

  logic [9:0] depth;
  logic [8:0] thr_full;
  logic       full;
  logic       empty;
  logic       wr_data;
  logic       rd_data;
  logic       do_push;
  logic       do_pop;
  logic       do_clear;
  logic       host_push;
  logic       drain;
  logic       stg_valid;
  logic [7:0] stg_data;
  logic       hi_now;
  logic       lo_now;
  logic [6:0] hw_a;
  logic       wr_irq_a;
  logic       wr_irq_b;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_byte;
  logic       acc_any;
  logic       wr_ctrl;
  logic       wr_thr;
  logic       err_wr_hit;

  // address hit decode, used by several strobes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // next buffer index; wraps at the selected depth, not at the array end
  function automatic logic [8:0] next_ptr(input logic [8:0] p, input logic [9:0] d);
    if ({1'b0, p} == d - 10'h001) begin
      next_ptr = 9'h000;
    end else begin
      next_ptr = p + 9'h001;
    end
  endfunction

  // rising edge of a level against its copy from the last cycle
  function automatic logic rise(input logic now, input logic prev);
    rise = now && !prev;
  endfunction

  // ----------------------------------------
  // access strobes
  // ----------------------------------------
  assign acc_any    = reg_wr || reg_rd;
  assign wr_ctrl    = reg_wr && hit(addr_ptr, OFS_CONTROL);
  assign wr_thr     = reg_wr && hit(addr_ptr, OFS_THRESHOLD);
  assign err_wr_hit = reg_wr && hit(addr_ptr, OFS_ERROR);
  assign wr_data  = reg_wr && hit(addr_ptr, OFS_DATA);
  assign rd_data  = reg_rd && hit(addr_ptr, OFS_DATA);
  assign wr_irq_a = reg_wr && hit(addr_ptr, OFS_IRQ_A);
  assign wr_irq_b = reg_wr && hit(addr_ptr, OFS_IRQ_B);
  assign do_clear = reg_wr && hit(addr_ptr, OFS_CONTROL)
                    && reg_wdata[BIT_CLEAR];

  // ----------------------------------------
  // depth and threshold
  // ----------------------------------------
  assign depth    = depth_sel_r ? DEPTH_SMALL : DEPTH_LARGE;
  assign thr_full = {thr_msb_r && !depth_sel_r, thr_r};
  assign full     = (cnt_r == depth);
  assign empty    = (cnt_r == 10'h000);

  // host has priority, modem bytes drain only on idle cycles
  assign host_push = wr_data && !full;
  assign drain     = stg_valid && !full && !reg_wr && !reg_rd;
  assign do_push   = host_push || drain;
  assign do_pop    = rd_data && !empty;

  // ----------------------------------------
  // alert comparisons
  // ----------------------------------------
  assign hi_now = ((depth - cnt_r) <= {1'b0, thr_full});
  assign lo_now = (cnt_r <= {1'b0, thr_full});

  // ----------------------------------------
  // staging fifo on the modem path
  // ----------------------------------------
  hfb_fifo #(
    .W (BYTE_W),
    .D (STAGE_DEPTH)
  ) u_stage (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (mdm_valid),
    .in_data   (mdm_data),
    .in_ready  (mdm_ready),
    .out_valid (stg_valid),
    .out_data  (stg_data),
    .out_ready (drain)
  );

  // address pointer, frozen on the data port
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_ptr <= RST_BYTE;
    end else if (acc_start) begin
      addr_ptr <= acc_addr;
    end else if (acc_any && !hit(addr_ptr, OFS_DATA)) begin
      addr_ptr <= addr_ptr + 8'h01;
    end
  end

  // depth select and threshold msb live in the control byte; a depth
  // change does not touch the pointers, so the host clears first
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      depth_sel_r <= RST_DEPTH;
      thr_msb_r   <= 1'b0;
    end else if (wr_ctrl) begin
      depth_sel_r <= reg_wdata[BIT_DEPTH_SEL];
      thr_msb_r   <= reg_wdata[BIT_THR_MSB];
    end
  end

  // threshold low byte, plain read/write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      thr_r <= RST_BYTE;
    end else if (wr_thr) begin
      thr_r <= reg_wdata;
    end
  end

  // write pointer wraps at the selected depth
  // changing depth with data inside leaves order undefined
  always_ff @(posedge clk) begin
    if (!reset_n || do_clear) begin
      wp_r <= 9'h000;
    end else if (do_push) begin
      wp_r <= next_ptr(wp_r, depth);
    end
  end

  // read pointer, same wrap
  always_ff @(posedge clk) begin
    if (!reset_n || do_clear) begin
      rp_r <= 9'h000;
    end else if (do_pop) begin
      rp_r <= next_ptr(rp_r, depth);
    end
  end

  // fill count
  always_ff @(posedge clk) begin
    if (!reset_n || do_clear) begin
      cnt_r <= 10'h000;
    end else if (do_push && !do_pop) begin
      cnt_r <= cnt_r + 10'h001;
    end else if (do_pop && !do_push) begin
      cnt_r <= cnt_r - 10'h001;
    end
  end

  // buffer storage
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_r[wp_r] <= host_push ? reg_wdata : stg_data;
    end
  end

  // overflow flag: set by a data write into a full buffer, cleared by
  // writing one to its error bit; set beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ovl_err_r <= 1'b0;
    end else if (wr_data && full) begin
      ovl_err_r <= 1'b1;
    end else if (err_wr_hit && reg_wdata[BIT_OVL_ERR]) begin
      ovl_err_r <= 1'b0;
    end
  end

  // write error flag: host pushes while modem bytes still wait, so
  // host and modem bytes interleave in the buffer; set beats clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_err_r <= 1'b0;
    end else if (wr_data && stg_valid) begin
      wr_err_r <= 1'b1;
    end else if (err_wr_hit && reg_wdata[BIT_WR_ERR]) begin
      wr_err_r <= 1'b0;
    end
  end

  // high alert level, one cycle behind the count
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      high_alert <= 1'b0;
    end else begin
      high_alert <= hi_now;
    end
  end

  // low alert level, same lag as the high alert
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_alert <= 1'b0;
    end else begin
      low_alert <= lo_now;
    end
  end

  // high alert copy from the last cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hi_prev_r <= 1'b0;
    end else begin
      hi_prev_r <= high_alert;
    end
  end

  // low alert copy from the last cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lo_prev_r <= 1'b0;
    end else begin
      lo_prev_r <= low_alert;
    end
  end

  // error history kept per flag, so a second flag rising while the
  // first still stands raises the event again
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ovl_prev_r    <= 1'b0;
      wr_err_prev_r <= 1'b0;
    end else begin
      ovl_prev_r    <= ovl_err_r;
      wr_err_prev_r <= wr_err_r;
    end
  end

  // ----------------------------------------
  // interrupt status registers
  // ----------------------------------------
  always_comb begin
    hw_a                = 7'h00;
    hw_a[BIT_HI_EVENT]  = rise(high_alert, hi_prev_r);
    hw_a[BIT_LO_EVENT]  = rise(low_alert, lo_prev_r);
    hw_a[BIT_ERR_EVENT] = rise(ovl_err_r, ovl_prev_r)
                          || rise(wr_err_r, wr_err_prev_r);
  end

  hfb_irq u_irq_a (
    .clk     (clk),
    .reset_n (reset_n),
    .wr      (wr_irq_a),
    .wdata   (reg_wdata),
    .hw_set  (hw_a),
    .status  (irq_a)
  );

  // second register has no sources inside this block
  hfb_irq u_irq_b (
    .clk     (clk),
    .reset_n (reset_n),
    .wr      (wr_irq_b),
    .wdata   (reg_wdata),
    .hw_set  (7'h00),
    .status  (irq_b)
  );

  // control readback: clear bit always zero
  always_comb begin
    ctrl_rd                 = 8'h00;
    ctrl_rd[BIT_DEPTH_SEL]  = depth_sel_r;
    ctrl_rd[BIT_HIGH_ALERT] = high_alert;
    ctrl_rd[BIT_LOW_ALERT]  = low_alert;
    ctrl_rd[BIT_THR_MSB]    = thr_msb_r;
    ctrl_rd[1:0]            = depth_sel_r ? 2'b00 : cnt_r[9:8];
  end

  // read multiplexer; unmapped addresses and empty pops give zero
  always_comb begin
    rd_byte = RST_BYTE;
    case (addr_ptr)
      OFS_CONTROL:   rd_byte = ctrl_rd;
      OFS_THRESHOLD: rd_byte = thr_r;
      OFS_FILL:      rd_byte = cnt_r[7:0];
      OFS_DATA:      rd_byte = empty ? RST_BYTE : mem_r[rp_r];
      OFS_IRQ_A:     rd_byte = {1'b0, irq_a};
      OFS_IRQ_B:     rd_byte = {1'b0, irq_b};
      OFS_ERROR:     rd_byte = {6'h00, ovl_err_r, wr_err_r};
      default:       rd_byte = RST_BYTE;
    endcase
  end

  // read byte, held until the next read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_byte;
    end
  end

  // valid pulse, one cycle after each read strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end
endmodule

// ---- hdl/hfb_pkg.sv ----
// shared constants for the host byte buffer block
//
// How it works
// - depth bit: 1 gives 255, 0 gives 512
// - high alert: depth minus count within threshold
// - low alert: count within threshold
// - clear bit empties buffer, reads zero
// - threshold bit 8 used in 512 mode only
// - control bits 1:0 hold count bits 9:8 in 512 mode, zero in 255 mode
// - threshold register is plain read/write byte
// - fill count low byte, resets to zero
// - data writes push, data reads pop
// - data port access keeps address pointer
// - bit 7 selects set or clear of ones
// - high alert rise latches its event bit
// - low alert rise latches its event bit
// - error flag rise sets error event bit
package hfb_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CONTROL   = 8'h02;
  localparam logic [7:0] OFS_THRESHOLD = 8'h03;
  localparam logic [7:0] OFS_FILL      = 8'h04;
  localparam logic [7:0] OFS_DATA      = 8'h05;
  localparam logic [7:0] OFS_IRQ_A     = 8'h06;
  localparam logic [7:0] OFS_IRQ_B     = 8'h07;
  localparam logic [7:0] OFS_ERROR     = 8'h0A;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_DEPTH_SEL   = 7;
  localparam int BIT_HIGH_ALERT  = 6;
  localparam int BIT_LOW_ALERT   = 5;
  localparam int BIT_CLEAR       = 4;
  localparam int BIT_THR_MSB     = 2;
  localparam int BIT_IRQ_SET     = 7;
  localparam int BIT_HI_EVENT    = 6;
  localparam int BIT_LO_EVENT    = 5;
  localparam int BIT_ERR_EVENT   = 1;
  localparam int BIT_WR_ERR      = 0;
  localparam int BIT_OVL_ERR     = 1;
  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam logic [9:0] DEPTH_SMALL = 10'h0FF;
  localparam logic [9:0] DEPTH_LARGE = 10'h200;
  localparam int         MEM_WORDS   = 512;
  localparam int         STAGE_DEPTH = 8;
  localparam int         BYTE_W      = 8;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic       RST_DEPTH   = 1'b0;
endpackage

// ---- hdl/hfb_fifo.sv ----
// small staging fifo between modem stream and main buffer
`timescale 1ns/1ps
module hfb_fifo
  import hfb_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,       // system clock
  input  wire logic         reset_n,   // sync reset, low
  input  wire logic         in_valid,  // source offers word
  input  wire logic [W-1:0] in_data,   // source word
  output logic              in_ready,  // room for a word
  output logic              out_valid, // word available
  output logic      [W-1:0] out_data,  // head word
  input  wire logic         out_ready  // sink takes word
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

  // occupancy next value
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // ready registered so the source sees a clean level
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_r    <= '0;
      in_ready <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      in_ready <= (cnt_nxt != (AW+1)'(D));
    end
  end

  // pointers wrap naturally, depth is a power of two
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

// ---- hdl/hfb_irq.sv ----
// interrupt request register with bit-7 set/clear write scheme
`timescale 1ns/1ps
module hfb_irq
  import hfb_pkg::*;
(
  input  wire logic       clk,     // system clock
  input  wire logic       reset_n, // sync reset, low
  input  wire logic       wr,      // host write strobe
  input  wire logic [7:0] wdata,   // host write byte
  input  wire logic [6:0] hw_set,  // hardware event pulses
  output logic      [6:0] status   // stored requests
);
  logic [6:0] sw_set;
  logic [6:0] sw_clr;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  assign sw_set = (wr && wdata[BIT_IRQ_SET])  ? wdata[6:0] : 7'h00;
  assign sw_clr = (wr && !wdata[BIT_IRQ_SET]) ? wdata[6:0] : 7'h00;

  // hardware set beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status <= 7'h00;
    end else begin
      status <= (status & ~sw_clr) | sw_set | hw_set;
    end
  end
endmodule

// ---- dv/hfb_top_asserts.sv ----
// concurrent checks on the host byte buffer top ports
`timescale 1ns/1ps
module hfb_top_asserts
  import hfb_pkg::*;
(
  input wire logic       clk,        // clock
  input wire logic       reset_n,    // sync reset, low
  input wire logic       acc_start,  // pointer load
  input wire logic [7:0] acc_addr,   // start address
  input wire logic       reg_wr,     // write strobe
  input wire logic       reg_rd,     // read strobe
  input wire logic [7:0] reg_wdata,  // write byte
  input wire logic [7:0] reg_rdata,  // read byte
  input wire logic       reg_rvalid, // read valid
  input wire logic [7:0] addr_ptr,   // pointer
  input wire logic       low_alert,  // low alert level
  input wire logic       high_alert, // high alert level
  input wire logic [6:0] irq_a,      // status a
  input wire logic [6:0] irq_b       // status b
);
  // ----------------------------------------
  // register port and status checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire acc_w = reg_wr | reg_rd; // any host access this cycle
  AST_RVALID: assert property (reg_rd |=> reg_rvalid)
    else $error("read gave no valid pulse");
  AST_PTR_LOAD: assert property (acc_start |=> addr_ptr == $past(acc_addr))
    else $error("pointer not loaded");
  AST_PTR_HOLD: assert property (acc_w && addr_ptr == OFS_DATA |=> $stable(addr_ptr))
    else $error("data port access moved pointer");
  AST_PTR_INC: assert property (acc_w && addr_ptr != OFS_DATA |=>
    addr_ptr == $past(addr_ptr) + 8'h01) else $error("pointer did not advance");
  AST_HI_EVENT: assert property ($rose(high_alert) |=> irq_a[BIT_HI_EVENT])
    else $error("high alert event missed");
  AST_LO_EVENT: assert property ($rose(low_alert) |=> irq_a[BIT_LO_EVENT])
    else $error("low alert event missed");
  AST_EVENT_HOLD: assert property (irq_a[BIT_HI_EVENT] &&
    !(reg_wr && addr_ptr == OFS_IRQ_A) |=> irq_a[BIT_HI_EVENT]) else $error("event lost");
  AST_IRQ_SET: assert property (reg_wr && addr_ptr == OFS_IRQ_B && reg_wdata[7] |=>
    ({1'b0, irq_b} & $past(reg_wdata) & 8'h7F) == ($past(reg_wdata) & 8'h7F))
    else $error("set write missed bits");
  AST_IRQ_CLR: assert property (reg_wr && addr_ptr == OFS_IRQ_B && !reg_wdata[7] |=>
    ({1'b0, irq_b} & $past(reg_wdata) & 8'h7F) == 8'h00) else $error("clear write missed");
  AST_CTRL_READ: assert property (reg_rd && addr_ptr == OFS_CONTROL |=>
    !reg_rdata[BIT_CLEAR] && reg_rdata[BIT_LOW_ALERT] == $past(low_alert))
    else $error("control read wrong");
  // main scenario covers
  COV_FULL: cover property ($rose(high_alert));
  COV_SET: cover property (reg_wr && addr_ptr == OFS_IRQ_B && reg_wdata[7]);
  COV_HOLD: cover property (reg_rd && addr_ptr == OFS_DATA);
endmodule

bind hfb_top hfb_top_asserts u_chk (.clk(clk), .reset_n(reset_n), .acc_start(acc_start),
  .acc_addr(acc_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .addr_ptr(addr_ptr),
  .low_alert(low_alert), .high_alert(high_alert), .irq_a(irq_a), .irq_b(irq_b));

// ---- dv/hfb_modem_model.sv ----
// modem side byte source feeding the staging stream
`timescale 1ns/1ps
module hfb_modem_model (
  input  wire logic       clk,       // clock
  input  wire logic       reset_n,   // sync reset, low
  input  wire logic [7:0] n_send,    // bytes to offer
  input  wire logic       stall,     // slow offers
  input  wire logic       mdm_ready, // sink room
  output logic            mdm_valid, // byte offered
  output logic      [7:0] mdm_data   // byte
);
  // ----------------------------------------
  // offer engine
  // ----------------------------------------
  logic [7:0] cnt_r;
  logic [7:0] data_r;
  logic       ph_r;
  // an offer is held until taken; stall only delays new ones
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mdm_valid <= 1'b0;
      cnt_r     <= 8'h00;
      data_r    <= 8'h10;
      ph_r      <= 1'b0;
    end else begin
      ph_r <= ~ph_r;
      if (mdm_valid && mdm_ready) begin
        mdm_valid <= 1'b0;
        cnt_r     <= cnt_r + 8'h01;
        data_r    <= data_r + 8'h01;
      end else if (!mdm_valid && cnt_r < n_send && !(stall && ph_r)) begin
        mdm_valid <= 1'b1;
      end
    end
  end
  // idle data shows junk so a stale byte never passes
  assign mdm_data = mdm_valid ? data_r : ~data_r;
endmodule

// ---- dv/tb_hfb_top.sv ----
// self-checking bench for the host byte buffer top
`timescale 1ns/1ps
module tb_hfb_top;
  import hfb_pkg::*;
  logic       clk, reset_n, acc_start, reg_wr, reg_rd, stall;
  logic [7:0] acc_addr, reg_wdata, d, n_send;
  wire  [7:0] reg_rdata, addr_ptr, mdm_data;
  wire        reg_rvalid, mdm_valid, mdm_ready, high_alert, low_alert;
  wire  [6:0] irq_a, irq_b;
  int         err_total, total_checks, cyc, n_hs;

  hfb_top dut (.clk(clk), .reset_n(reset_n), .acc_start(acc_start), .acc_addr(acc_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .addr_ptr(addr_ptr), .mdm_valid(mdm_valid),
    .mdm_data(mdm_data), .mdm_ready(mdm_ready), .high_alert(high_alert),
    .low_alert(low_alert), .irq_a(irq_a), .irq_b(irq_b));
  hfb_modem_model u_mdm (.clk(clk), .reset_n(reset_n), .n_send(n_send), .stall(stall),
    .mdm_ready(mdm_ready), .mdm_valid(mdm_valid), .mdm_data(mdm_data));

  // ----------------------------------------
  // clock, hang guard, stream monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ceiling sits well above the roughly two thousand cycles used
  always @(posedge clk) begin
    cyc++;
    if (mdm_valid && mdm_ready) n_hs++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic setp(input logic [7:0] a);
    @(negedge clk);
    acc_start = 1'b1;
    acc_addr  = a;
    @(negedge clk);
    acc_start = 1'b0;
  endtask
  task automatic wb(input logic [7:0] v);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_wdata = v;
    @(negedge clk);
    reg_wr    = 1'b0;
  endtask
  // read at pointer; valid is due one cycle after the strobe
  task automatic rd(input logic [7:0] a);
    setp(a);
    @(negedge clk);
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({7'h00, reg_rvalid}, 8'h01);
    d = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    setp(a);
    wb(v);
  endtask
  // extra cycle lets the registered alerts catch up
  task automatic push(input int n, input logic [7:0] base);
    setp(OFS_DATA);
    for (int i = 0; i < n; i++) wb(base + i[7:0]);
    @(negedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(OFS_CONTROL);
    chk(d, 8'h20);
    rd(OFS_FILL);
    chk(d, 8'h00);
    chk({1'b0, irq_a}, 8'h20);
  endtask
  task automatic t_irq();
    wr(OFS_IRQ_A, 8'h7F);
    chk({1'b0, irq_a}, 8'h00);
    wr(OFS_IRQ_B, 8'h85);
    chk({1'b0, irq_b}, 8'h05);
    wr(OFS_IRQ_B, 8'h04);
    chk({1'b0, irq_b}, 8'h01);
    wr(OFS_IRQ_B, 8'hFF);
    chk({1'b0, irq_b}, 8'h7F);
    wr(OFS_IRQ_B, 8'h7F);
    chk({1'b0, irq_b}, 8'h00);
  endtask
  task automatic t_data();
    wr(OFS_THRESHOLD, 8'h02);
    rd(OFS_THRESHOLD);
    chk(d, 8'h02);
    push(3, 8'hA0);
    chk(addr_ptr, OFS_DATA);
    chk({7'h00, low_alert}, 8'h00);
    rd(OFS_FILL);
    chk(d, 8'h03);
    chk(addr_ptr, 8'h05);
    rd(OFS_DATA);
    chk(d, 8'hA0);
    rd(OFS_FILL);
    chk(d, 8'h02);
    chk({7'h00, low_alert}, 8'h01);
    chk({1'b0, irq_a & 7'h20}, 8'h20);
  endtask
  task automatic t_full();
    wr(OFS_CONTROL, 8'h10);
    rd(OFS_FILL);
    chk(d, 8'h00);
    push(512, 8'h00);
    push(1, 8'hEE);
    chk({7'h00, high_alert}, 8'h01);
    rd(OFS_ERROR);
    chk(d, 8'h02);
    rd(OFS_CONTROL);
    chk(d, 8'h42);
    rd(OFS_FILL);
    chk(d, 8'h00);
    chk({1'b0, irq_a & 7'h42}, 8'h42);
    rd(OFS_DATA);
    chk(d, 8'h00);
    rd(OFS_CONTROL);
    chk(d, 8'h41);
  endtask
  task automatic t_small();
    wr(OFS_CONTROL, 8'h94);
    push(3, 8'h01);
    chk({7'h00, low_alert}, 8'h00);
    push(253, 8'h04);
    rd(OFS_CONTROL);
    chk(d, 8'hC4);
    rd(OFS_FILL);
    chk(d, 8'hFF);
    wr(OFS_CONTROL, 8'h14);
    push(3, 8'h01);
    chk({7'h00, low_alert}, 8'h01);
  endtask
  // host reads on unmapped space block draining until stage refuses
  task automatic t_stream();
    wr(OFS_IRQ_A, 8'h02);
    wr(OFS_CONTROL, 8'h10);
    setp(8'h20);
    @(negedge clk);
    n_send = 8'h0C;
    stall  = 1'b1;
    reg_rd = 1'b1;
    repeat (40) @(negedge clk);
    chk({7'h00, mdm_ready}, 8'h00);
    chk(reg_rdata, 8'h00);
    reg_rd = 1'b0;
    stall  = 1'b0;
    push(1, 8'h55);
    chk({1'b0, irq_a & 7'h02}, 8'h02);
    for (int k = 0; k < 200 && n_hs < 12; k++) @(negedge clk);
    repeat (6) @(negedge clk);
    rd(OFS_FILL);
    chk(d, 8'h0D);
    rd(OFS_DATA);
    chk(d, 8'h10);
    rd(OFS_ERROR);
    chk(d, 8'h03);
    wr(OFS_ERROR, 8'h03);
    rd(OFS_ERROR);
    chk(d, 8'h00);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    reset_n   = 1'b0;
    acc_start = 1'b0;
    acc_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
    n_send    = 8'h00;
    stall     = 1'b0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_irq();
    t_data();
    t_full();
    t_small();
    t_stream();
    report_and_stop();
  end
endmodule
